// ==== mbpwm_defs.vh ====
`ifndef MBPWM_DEFS_VH
`define MBPWM_DEFS_VH
// register byte offsets
`define MBPWM_IR_OFS      12'h000
`define MBPWM_TCR_OFS     12'h004
`define MBPWM_TC_OFS      12'h008
`define MBPWM_PR_OFS      12'h00c
`define MBPWM_PC_OFS      12'h010
`define MBPWM_MCR_OFS     12'h014
`define MBPWM_MATCH_OFS   12'h018
`define MBPWM_MATCH_LAST  12'h030
`define MBPWM_PCR_OFS     12'h04c
`define MBPWM_LER_OFS     12'h050
`define MBPWM_MASK_OFS    12'h054
// timer control bits
`define MBPWM_TCR_EN      0
`define MBPWM_TCR_RST     1
`define MBPWM_TCR_PWM     3
// match control field: interrupt, reset, stop per match
`define MBPWM_MCR_INT     0
`define MBPWM_MCR_RST     1
`define MBPWM_MCR_STOP    2
// output control: bits 2..6 select double edge, bits 9..14 enable
`define MBPWM_PCR_SEL     2
`define MBPWM_PCR_ENA     9
// reset values
`define MBPWM_MATCH_RST   32'h00000000
`define MBPWM_CTRL_RST    32'h00000000
`define MBPWM_NMATCH      7
`define MBPWM_NOUT        6
`endif

// ==== mbpwm_match_mem.v ====
`include "mbpwm_defs.vh"
// seven-entry match store, registered read port
module mbpwm_match_mem (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // write port
  input  wire        wr_en,
  input  wire [2:0]  wr_idx,
  input  wire [31:0] wr_data,
  // read port
  input  wire [2:0]  rd_idx,
  output reg  [31:0] rd_data,
  // whole content, for the shadow load
  output wire [223:0] all_data
);
  reg [31:0] mem [0:6];
  genvar g;
  // write side and flat view of every entry
  generate
    for (g = 0; g < `MBPWM_NMATCH; g = g + 1) begin : ent
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          mem[g] <= `MBPWM_MATCH_RST;
        end else if (wr_en && wr_idx == g) begin
          mem[g] <= wr_data;
        end
      end
      assign all_data[32*g+31:32*g] = mem[g];
    end
  endgenerate
  // registered read, out of range reads as zero
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 32'h00000000;
    end else if (rd_idx < 3'h7) begin
      rd_data <= mem[rd_idx];
    end else begin
      rd_data <= 32'h00000000;
    end
  end
endmodule

// ==== mbpwm_unit.v ====
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`include "mbpwm_defs.vh"
module mbpwm_unit (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // modulated outputs
  output reg  [5:0]  pwm_out,
  // interrupt
  output reg         irq
);
  // control and status registers
  reg  [1:0]   run_ctrl;      // bit0 enable, bit1 hold in reset
  reg          pwm_mode;
  reg  [31:0]  timer_count;
  reg  [31:0]  prescale_limit;
  reg  [31:0]  prescale_count;
  reg  [20:0]  match_ctrl;
  reg  [14:0]  out_ctrl;
  reg  [6:0]   release_mask;
  reg  [6:0]   irq_status;
  reg  [6:0]   irq_mask;
  reg  [31:0]  active_match [0:6];
  reg          rd_pend;
  reg          mem_rd;
  reg  [31:0]  rd_hold;
  reg  [31:0]  next_rd;
  reg          hit_err;
  wire         setup;
  wire         wr_acc;
  wire         match_sel;
  wire [2:0]   match_idx;
  wire [31:0]  mem_q;
  wire [223:0] written_match;
  wire         tick;
  wire [6:0]   hit;
  wire [6:0]   hit_rst;
  wire [6:0]   hit_stop;
  wire         period_hit;
  wire [11:0]  match_off;

  assign setup     = psel && !penable;
  assign wr_acc    = psel && penable && pready && pwrite;
  assign match_off = paddr - `MBPWM_MATCH_OFS;
  assign match_sel = (paddr >= `MBPWM_MATCH_OFS) && (paddr <= `MBPWM_MATCH_LAST) && (paddr[1:0] == 2'h0);
  assign match_idx = match_off[4:2];

  // written match values live in the small store; active copies below
  mbpwm_match_mem u_mem (
    .clock    (clock),
    .reset_n  (reset_n),
    .wr_en    (wr_acc && match_sel),
    .wr_idx   (match_idx),
    .wr_data  (pwdata),
    .rd_idx   (match_idx),
    .rd_data  (mem_q),
    .all_data (written_match)
  );

  // prescaler tick once the prescale count reaches its limit
  assign tick = run_ctrl[`MBPWM_TCR_EN] && !run_ctrl[`MBPWM_TCR_RST]
                && (prescale_count == prescale_limit);

  // compare every active match against the counter
  genvar g;
  generate
    for (g = 0; g < `MBPWM_NMATCH; g = g + 1) begin : cmp
      assign hit[g]      = tick && (timer_count == active_match[g]);
      assign hit_rst[g]  = hit[g] && match_ctrl[3*g+`MBPWM_MCR_RST];
      assign hit_stop[g] = hit[g] && match_ctrl[3*g+`MBPWM_MCR_STOP];
    end
  endgenerate
  // in modulation mode match 0 always closes the cycle
  assign period_hit = hit[0] && (pwm_mode || match_ctrl[`MBPWM_MCR_RST]);

  // prescaler and counter; reset on match wraps to zero
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prescale_count <= 32'h00000000;
      timer_count    <= 32'h00000000;
    end else if (run_ctrl[`MBPWM_TCR_RST]) begin
      prescale_count <= 32'h00000000;
      timer_count    <= 32'h00000000;
    end else if (run_ctrl[`MBPWM_TCR_EN]) begin
      if (tick) begin
        prescale_count <= 32'h00000000;
        if (period_hit || (|hit_rst)) begin
          timer_count <= 32'h00000000;
        end else if (!(|hit_stop)) begin
          timer_count <= timer_count + 32'h00000001; // a stop match holds the matching count
        end
      end else begin
        prescale_count <= prescale_count + 32'h00000001;
      end
    end
  end

  // shadow load: released values copy in at the cycle boundary in modulation mode, at once otherwise
  generate
    for (g = 0; g < `MBPWM_NMATCH; g = g + 1) begin : shd
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          active_match[g] <= `MBPWM_MATCH_RST;
        end else if (release_mask[g] && (period_hit || !pwm_mode)) begin
          active_match[g] <= written_match[32*g+31:32*g];
        end
      end
    end
  endgenerate

  // release bits clear once taken; a new release in the same cycle wins
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      release_mask <= 7'h00;
    end else if (wr_acc && paddr == `MBPWM_LER_OFS) begin
      // bits taken at this edge drop, so a stale release cannot apply a later write
      release_mask <= ((period_hit || !pwm_mode) ? 7'h00 : release_mask) | pwdata[6:0];
    end else if (period_hit || !pwm_mode) begin
      release_mask <= 7'h00;
    end
  end

  // outputs: channel n (1..6) single edge set by period, cleared by match n;
  // double edge set by match n-1, cleared by match n
  generate
    for (g = 1; g <= `MBPWM_NOUT; g = g + 1) begin : outp
      wire dbl;
      wire set_e;
      wire clr_e;
      if (g == 1) begin : sgl_only
        assign dbl = 1'b0; // first output has no double form
      end else begin : sel
        assign dbl = out_ctrl[g];
      end
      assign set_e = dbl ? hit[g-1] : hit[0];
      assign clr_e = hit[g];
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pwm_out[g-1] <= 1'b0;
        end else if (!pwm_mode || !out_ctrl[`MBPWM_PCR_ENA+g-1]) begin
          pwm_out[g-1] <= 1'b0;
        end else if (clr_e && !(dbl && set_e)) begin
          pwm_out[g-1] <= 1'b0;
        end else if (set_e && !clr_e) begin
          pwm_out[g-1] <= 1'b1;
        end else if (set_e && clr_e && dbl) begin
          pwm_out[g-1] <= 1'b0; // equal edges: no pulse
        end
      end
    end
  endgenerate

  // control registers; stop on match clears the enable
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_ctrl       <= 2'h0;
      pwm_mode       <= 1'b0;
      prescale_limit <= `MBPWM_CTRL_RST;
      match_ctrl     <= 21'h000000;
      out_ctrl       <= 15'h0000;
      irq_mask       <= 7'h00;
    end else begin
      if (wr_acc && paddr == `MBPWM_TCR_OFS) begin
        run_ctrl <= {pwdata[`MBPWM_TCR_RST], pwdata[`MBPWM_TCR_EN]};
        pwm_mode <= pwdata[`MBPWM_TCR_PWM];
      end else if (|hit_stop) begin
        run_ctrl[`MBPWM_TCR_EN] <= 1'b0;
      end
      if (wr_acc && paddr == `MBPWM_PR_OFS) begin
        prescale_limit <= pwdata;
      end
      if (wr_acc && paddr == `MBPWM_MCR_OFS) begin
        match_ctrl <= pwdata[20:0];
      end
      if (wr_acc && paddr == `MBPWM_PCR_OFS) begin
        out_ctrl <= pwdata[14:0];
      end
      if (wr_acc && paddr == `MBPWM_MASK_OFS) begin
        irq_mask <= pwdata[6:0];
      end
    end
  end

  // sticky match flags, write one to clear; a new hit wins
  generate
    for (g = 0; g < `MBPWM_NMATCH; g = g + 1) begin : flg
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          irq_status[g] <= 1'b0;
        end else if (hit[g] && match_ctrl[3*g+`MBPWM_MCR_INT]) begin
          irq_status[g] <= 1'b1;
        end else if (wr_acc && paddr == `MBPWM_IR_OFS && pwdata[g]) begin
          irq_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // level interrupt from a flop
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // read mux for the plain registers
  always @* begin
    next_rd = 32'h00000000;
    hit_err = 1'b0;
    case (paddr)
      `MBPWM_IR_OFS:   next_rd = {25'h0000000, irq_status};
      `MBPWM_TCR_OFS:  next_rd = {28'h0000000, pwm_mode, 1'b0, run_ctrl};
      `MBPWM_TC_OFS:   next_rd = timer_count;
      `MBPWM_PR_OFS:   next_rd = prescale_limit;
      `MBPWM_PC_OFS:   next_rd = prescale_count;
      `MBPWM_MCR_OFS:  next_rd = {11'h000, match_ctrl};
      `MBPWM_PCR_OFS:  next_rd = {17'h00000, out_ctrl};
      `MBPWM_LER_OFS:  next_rd = {25'h0000000, release_mask};
      `MBPWM_MASK_OFS: next_rd = {25'h0000000, irq_mask};
      default:         hit_err = !match_sel;
    endcase
  end

  // apb: setup latches read data, access answers one cycle later
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      rd_pend <= 1'b0;
      mem_rd  <= 1'b0;
      rd_hold <= 32'h00000000;
    end else if (setup) begin
      rd_pend <= 1'b1;
      mem_rd  <= match_sel;
      rd_hold <= next_rd;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else if (psel && penable && rd_pend && !pready) begin
      pready  <= 1'b1;
      pslverr <= hit_err;
      prdata  <= pwrite ? 32'h00000000 : (mem_rd ? mem_q : rd_hold);
      rd_pend <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// ==== mbpwm_unit_sva.sv ====
`include "mbpwm_defs.vh"
module mbpwm_unit_sva (
  // clock and reset
  input wire        clock,
  input wire        reset_n,
  // register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // pins
  input wire [5:0]  pwm_out,
  input wire        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // end of an access, and a hole in the map used as the refused address
  wire fin = psel && penable && pready;
  wire gap = paddr == 12'h040;
  ack_delay_a: assert property (psel && !penable |-> ##2 pready) else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  ready_cause_a: assert property (pready |-> psel && penable) else $error("ready unasked");
  err_ready_a: assert property (pslverr |-> pready) else $error("error alone");
  gap_refused_a: assert property (fin && gap |-> pslverr && prdata == 32'h0) else $error("hole taken");
  map_taken_a: assert property (fin && paddr == `MBPWM_TCR_OFS |-> !pslverr) else $error("ctrl refused");
  // a zero mask silences the line one or two clocks later, whatever the flags do
  mask_quiet_a: assert property (fin && pwrite && paddr == `MBPWM_MASK_OFS && pwdata == 32'h0
    |-> ##[1:2] !irq) else $error("masked irq");
  reset_clean_a: assert property ($rose(reset_n) |-> pwm_out == 6'h00 && !irq) else $error("dirty reset");
  cover property (fin && pslverr);
  cover property ($rose(irq));
  cover property ($rose(pwm_out[1]));
endmodule
bind mbpwm_unit mbpwm_unit_sva u_sva (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_out(pwm_out), .irq(irq));

// ==== mbpwm_load.sv ====
module mbpwm_load (
  // clock and reset
  input  wire              clock,
  input  wire              reset_n,
  // pins and window control
  input  wire  [5:0]       pwm_out,
  input  wire              clear,
  // tallies per output
  output logic [5:0][7:0]  high_cnt,
  output logic [5:0][7:0]  rise_cnt
);
  logic [5:0] last;
  // a power stage sees only levels; tallies wrap past 255, so windows stay short
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last <= 6'h00;
      high_cnt <= 48'h0;
      rise_cnt <= 48'h0;
    end else begin
      last <= pwm_out;
      for (int i = 0; i < 6; i++) begin
        high_cnt[i] <= clear ? 8'h00 : high_cnt[i] + 8'(pwm_out[i]);
        rise_cnt[i] <= clear ? 8'h00 : rise_cnt[i] + 8'(pwm_out[i] & ~last[i]);
      end
    end
  end
endmodule

// ==== mbpwm_unit_test.sv ====
`include "mbpwm_defs.vh"
module mbpwm_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clock = 1'b0, reset_n = 1'b0, clear = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic            pready, pslverr, irq, err;
  logic [5:0]      pwm_out;
  logic [5:0][7:0] hi, ri;
  int              err_total = 0, num_checks = 0;
  localparam logic [11:0] mo = `MBPWM_MATCH_OFS;
  always #2 clock = ~clock;
  mbpwm_unit u_dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
    .irq(irq));
  mbpwm_load u_load (.clock(clock), .reset_n(reset_n), .pwm_out(pwm_out), .clear(clear), .high_cnt(hi),
    .rise_cnt(ri));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one transfer; waits for ready, not a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    cmp("ready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
  endtask
  // settle, then tally exactly 100 samples; any 100-clock window holds whole periods of ten
  task automatic span;
    repeat (40) @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (100) @(posedge clock);
    @(negedge clock);
  endtask
  // reset value and the refused hole
  task automatic t_regs;
    chk("ctrl", `MBPWM_TCR_OFS, `MBPWM_CTRL_RST);
    wr(12'h040, 32'hffffffff);
    cmp("refused", 1, err);
    chk("hole", 12'h040, 32'h0);
  endtask
  // plain timer: prescaled, stop and flag on match
  task automatic t_timer;
    wr(`MBPWM_MCR_OFS, 32'h5);
    wr(mo, 32'h4);
    wr(`MBPWM_LER_OFS, 32'h1);
    wr(`MBPWM_PR_OFS, 32'h2);
    wr(`MBPWM_MASK_OFS, 32'h1);
    wr(`MBPWM_TCR_OFS, 32'h1);
    repeat (8) @(posedge clock);
    cmp("irq early", 0, irq);
    repeat (30) @(posedge clock);
    cmp("irq", 1, irq);
    chk("stop count", `MBPWM_TC_OFS, 32'h4);
    chk("flags", `MBPWM_IR_OFS, 32'h1);
    cmp("plain pins", 0, pwm_out);
    wr(`MBPWM_IR_OFS, 32'h1);
    chk("cleared", `MBPWM_IR_OFS, 32'h0);
    cmp("irq off", 0, irq);
    wr(`MBPWM_MASK_OFS, 32'h0);
    wr(`MBPWM_TCR_OFS, 32'h2);
    wr(`MBPWM_TCR_OFS, 32'h1);
    repeat (40) @(posedge clock);
    cmp("masked", 0, irq);
    wr(`MBPWM_IR_OFS, 32'h1);
  endtask
  // output 1 single edge, period ten ticks, staged update
  task automatic t_single;
    wr(`MBPWM_MCR_OFS, 32'h2);
    wr(`MBPWM_PR_OFS, 32'h0);
    wr(mo, 32'h9);
    wr(mo + 12'h4, 32'h3);
    wr(`MBPWM_LER_OFS, 32'h3);
    wr(`MBPWM_PCR_OFS, 32'h200);
    wr(`MBPWM_TCR_OFS, 32'h2);
    wr(`MBPWM_TCR_OFS, 32'h9);
    span;
    cmp("rises", 10, ri[0]);
    cmp("high", 40, hi[0]);
    cmp("idle", 0, hi[1]);
    wr(mo + 12'h4, 32'h6);
    chk("written", mo + 12'h4, 32'h6);
    span;
    cmp("held", 40, hi[0]);
    wr(`MBPWM_LER_OFS, 32'h2);
    span;
    cmp("released", 70, hi[0]);
    wr(mo, 32'h13);
    wr(`MBPWM_LER_OFS, 32'h1);
    span;
    cmp("slow rises", 5, ri[0]);
    cmp("slow high", 35, hi[0]);
  endtask
  // output 2 double edge beside single outputs 1 and 6
  task automatic t_double;
    wr(mo, 32'h9);
    wr(mo + 12'h4, 32'h1);
    wr(mo + 12'h8, 32'h7);
    wr(mo + 12'h18, 32'h5);
    wr(`MBPWM_LER_OFS, 32'h47);
    wr(`MBPWM_PCR_OFS, 32'h4604);
    span;
    cmp("out1", 20, hi[0]);
    cmp("positive", 60, hi[1]);
    cmp("out6", 60, hi[5]);
    wr(mo + 12'h4, 32'h7);
    wr(mo + 12'h8, 32'h1);
    wr(`MBPWM_LER_OFS, 32'h6);
    span;
    cmp("negative", 40, hi[1]);
    cmp("out2 rises", 10, ri[1]);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    t_regs;
    t_timer;
    t_single;
    t_double;
    finish_test;
  end
  // hang guard, several times the expected run
  initial begin
    #40000;
    err_total++;
    finish_test;
  end
endmodule
